// *** rtl/thc_pkg.sv ***
// Constants shared by the temperature histogram command block
package thc_pkg;
   // ****************************************
   // Register map (byte addresses on APB)
   // ****************************************
   localparam int          ADDR_W       = 8;
   localparam logic [7:0]  OFS_HDR0     = 8'h00;  // Command bytes 128-131
   localparam logic [7:0]  OFS_HDR1     = 8'h04;  // Command bytes 132-135
   localparam logic [7:0]  OFS_ACT      = 8'h08;  // Command byte 136
   localparam logic [7:0]  OFS_START    = 8'h0c;  // Bit 0 launches the command
   localparam logic [7:0]  OFS_STAT     = 8'h10;  // Result code and done flag
   localparam logic [7:0]  OFS_REPLY    = 8'h40;  // Reply bytes 136-187, 13 words
   localparam int          STAT_DONE_B  = 8;
   localparam int          STAT_BUSY_B  = 9;

   // ****************************************
   // Command fields and codes
   // ****************************************
   localparam logic [15:0] CMD_ID       = 16'h0290;
   localparam logic [15:0] EPL_EXP      = 16'h0000;
   localparam logic [7:0]  LPL_EXP      = 8'h01;
   localparam logic [7:0]  RPL_LEN      = 8'h34;  // 52 reply bytes
   localparam int          ACT_SAVE_B   = 1;
   localparam int          ACT_RET_B    = 2;
   localparam int          ACT_CLR_B    = 7;
   localparam logic [7:0]  ACT_RSVD_M   = 8'h79;  // Bits 0 and 3-6
   localparam logic [7:0]  RC_IDLE      = 8'h00;
   localparam logic [7:0]  RC_CAPT      = 8'h81;
   localparam logic [7:0]  RC_CHECK     = 8'h82;
   localparam logic [7:0]  RC_EXEC      = 8'h83;
   localparam logic [7:0]  RC_OK        = 8'h01;
   localparam logic [7:0]  RC_FAIL      = 8'h40;
   localparam logic [7:0]  RC_PARAM     = 8'h42;
   localparam logic [7:0]  RC_CHK       = 8'h45;

   // ****************************************
   // Histogram layout and timing
   // ****************************************
   localparam int          NBINS        = 11;     // Below -5, nine 10 degC bins, 85 up
   localparam int          NWORDS       = NBINS + 1;
   localparam int          BIN_LO_C     = -5;
   localparam int          BIN_STEP_C   = 10;
   localparam logic [7:0]  HOURS_DEF    = 8'hff;  // Host must trigger every save
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          SAMPLE_NS    = 1000000000;
   localparam int          SEC_CYCLES   = SAMPLE_NS / CLK_PERIOD_NS;

   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_CAPT  = 5'b00010,
      S_CHECK = 5'b00100,
      S_EXEC  = 5'b01000,
      S_FIN   = 5'b10000
   } thc_state_t;
endpackage

// *** rtl/thc_cmd.sv ***
// Temperature histogram command interpreter with APB register access
//
// Notes on behaviour
// (RL1) Count seconds per temperature bin since clear
// (RL2) Command identifier 0290h in bytes 128-129
// (RL3) Host sends zero extended, one local byte
// (RL4) Verify command check code before executing
// (RL5) Host may preload reply length and check
// (RL6) Action bit 1 saves histogram to store
// (RL7) Action bit 2 returns 10 degC bins
// (RL8) Action bit 7 clears histogram, persistently
// (RL9) Reserved action bits, bytes 137-255 by host
// (RL10) Raise done flag when command finishes
// (RL11) Progress codes: captured, checking, executing
// (RL12) Success writes result code 00 000001b
// (RL13) Failure codes: unspecified, parameter, check mismatch
// (RL14) Reply length 52 plus reply check code
// (RL15) Echo action byte into reply byte 136
// (RL16) Reply byte 137 gives hours to save
// (RL17) Value 255: host must trigger saves
// (RL18) Host saves before removing the module
// (RL19) Sampling and save intervals are ours
// (RL20) Reply total seconds at bytes 140-143
// (RL21) Bin counters follow, lowest bin first
// (RL22) Done flag only after reply complete
`timescale 1ns/1ns
module thc_cmd #(
   parameter int          SEC_CYC    = thc_pkg::SEC_CYCLES,
   parameter logic [7:0]  HOURS_SAVE = thc_pkg::HOURS_DEF
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic signed [7:0] temp_degc,
   output logic                   nv_save_req,
   output logic                   command_done_flag,
   output logic      [7:0]        command_result_code
);
   localparam int TICK_W = $clog2(SEC_CYC);

   // ****************************************
   // Helpers
   // ****************************************
   // Plain byte sum of a word; both check codes invert it
   function automatic logic [7:0] bsum(input logic [31:0] w);
      bsum = w[7:0] + w[15:8] + w[23:16] + w[31:24];
   endfunction

   // Bin index: number of bin edges at or below the sample
   function automatic logic [3:0] bin_of(input logic signed [7:0] t);
      logic [3:0] k;
      k = 4'h0;
      for (int i = 0; i < thc_pkg::NBINS - 1; i++) begin
         if (int'(t) >= thc_pkg::BIN_LO_C + thc_pkg::BIN_STEP_C * i) begin
            k = 4'(i + 1);
         end
      end
      bin_of = k;
   endfunction

   thc_pkg::thc_state_t state_ff, nxt_state;
   logic [7:0]          rc_ff, nxt_rc;
   logic                done_ff, nxt_done;
   logic [31:0]         hdr0_ff, nxt_hdr0;
   logic [31:0]         hdr1_ff, nxt_hdr1;
   logic [7:0]          act_ff, nxt_act;
   logic [31:0]         reply_ff [thc_pkg::NWORDS];
   logic [31:0]         nxt_reply [thc_pkg::NWORDS];
   logic                save_ff, nxt_save;
   logic [31:0]         cnt_ff [thc_pkg::NWORDS];
   logic [31:0]         nxt_cnt [thc_pkg::NWORDS];
   logic [TICK_W-1:0]   tick_ff, nxt_tick;
   logic [31:0]         prdata_ff, nxt_prdata;
   logic                wr_acc;
   logic                clr_hist;
   logic [31:0]         word0;
   logic [7:0]          cmd_chk;
   logic [7:0]          rpl_chk;
   logic                mapped;
   logic                reply_hit;
   logic [3:0]          reply_idx;
   logic [3:0]          bin_idx;

   // ****************************************
   // APB decode
   // ****************************************
   // Zero wait states; read data is caught at the setup edge
   assign pready    = 1'b1;
   assign wr_acc    = psel & penable & pwrite;
   assign reply_hit = (paddr >= thc_pkg::OFS_REPLY) && (paddr[1:0] == 2'b00) &&
                      (paddr < thc_pkg::OFS_REPLY + 8'(4 * (thc_pkg::NWORDS + 1)));
   assign reply_idx = 4'((paddr - thc_pkg::OFS_REPLY) >> 2);
   assign mapped    = reply_hit || paddr == thc_pkg::OFS_HDR0 ||
                      paddr == thc_pkg::OFS_HDR1 || paddr == thc_pkg::OFS_ACT ||
                      paddr == thc_pkg::OFS_START || paddr == thc_pkg::OFS_STAT;
   assign pslverr   = psel & penable & ~mapped;
   assign prdata    = prdata_ff;

   // Reply bytes 136-139: echo, hours to save, two reserved
   assign word0   = {16'h0000, HOURS_SAVE, act_ff}; // RL15 RL16 RL17
   // Check over bytes 128-132 and the single payload byte
   assign cmd_chk = ~(bsum(hdr0_ff) + hdr1_ff[7:0] + act_ff); // RL4

   // Reply check covers all 52 reply bytes; built from the counters, not the
   // sequencer outputs, so no loop forms through the next-state logic
   always_comb begin
      logic [7:0] s;
      s = bsum(word0);
      for (int i = 0; i < thc_pkg::NWORDS; i++) begin
         s = s + bsum(act_ff[thc_pkg::ACT_RET_B] ? cnt_ff[i] : 32'h0000_0000);
      end
      rpl_chk = ~s; // RL14
   end

   // Read mux for the next access phase
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
         if (reply_hit) begin
            nxt_prdata = (reply_idx == 4'h0) ? word0 : reply_ff[reply_idx - 4'h1];
         end else begin
            case (paddr)
               thc_pkg::OFS_HDR0: nxt_prdata = hdr0_ff;
               thc_pkg::OFS_HDR1: nxt_prdata = hdr1_ff;
               thc_pkg::OFS_ACT:  nxt_prdata = {24'h000000, act_ff};
               thc_pkg::OFS_STAT: nxt_prdata = {22'h000000, state_ff != thc_pkg::S_IDLE,
                                                done_ff, rc_ff};
               default:           nxt_prdata = 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************************
   // Command sequencer
   // ****************************************
   // Command bytes are writable only while idle, so a running command sees
   // stable inputs; writes while busy are dropped without an error.
   always_comb begin
      nxt_state = state_ff;
      nxt_rc    = rc_ff;
      nxt_done  = done_ff;
      nxt_hdr0  = hdr0_ff;
      nxt_hdr1  = hdr1_ff;
      nxt_act   = act_ff;
      nxt_save  = 1'b0;
      for (int i = 0; i < thc_pkg::NWORDS; i++) begin
         nxt_reply[i] = reply_ff[i];
      end
      case (state_ff)
         thc_pkg::S_IDLE: begin
            if (wr_acc && paddr == thc_pkg::OFS_HDR0) begin
               nxt_hdr0 = pwdata;
            end
            if (wr_acc && paddr == thc_pkg::OFS_HDR1) begin
               nxt_hdr1 = pwdata; // RL5
            end
            if (wr_acc && paddr == thc_pkg::OFS_ACT) begin
               nxt_act = pwdata[7:0];
            end
            if (wr_acc && paddr == thc_pkg::OFS_START && pwdata[0]) begin
               nxt_state = thc_pkg::S_CAPT;
               nxt_rc    = thc_pkg::RC_CAPT; // RL11
               nxt_done  = 1'b0;
            end
         end
         thc_pkg::S_CAPT: begin
            nxt_state = thc_pkg::S_CHECK;
            nxt_rc    = thc_pkg::RC_CHECK; // RL11
         end
         thc_pkg::S_CHECK: begin
            // Identifier first, then check code, then parameters
            if ({hdr0_ff[7:0], hdr0_ff[15:8]} != thc_pkg::CMD_ID) begin // RL2
               nxt_state = thc_pkg::S_FIN;
               nxt_rc    = thc_pkg::RC_FAIL; // RL13
            end else if (hdr1_ff[15:8] != cmd_chk) begin // RL4
               nxt_state = thc_pkg::S_FIN;
               nxt_rc    = thc_pkg::RC_CHK; // RL13
            end else if ({hdr0_ff[23:16], hdr0_ff[31:24]} != thc_pkg::EPL_EXP ||
                         hdr1_ff[7:0] != thc_pkg::LPL_EXP ||
                         (act_ff & thc_pkg::ACT_RSVD_M) != 8'h00) begin
               nxt_state = thc_pkg::S_FIN;
               nxt_rc    = thc_pkg::RC_PARAM; // RL13
            end else begin
               nxt_state = thc_pkg::S_EXEC;
               nxt_rc    = thc_pkg::RC_EXEC; // RL11
            end
         end
         thc_pkg::S_EXEC: begin
            // Snapshot taken before any clear in the same command
            for (int i = 0; i < thc_pkg::NWORDS; i++) begin
               nxt_reply[i] = act_ff[thc_pkg::ACT_RET_B] ? cnt_ff[i] : 32'h0000_0000; // RL7 RL20 RL21
            end
            nxt_hdr1[23:16] = thc_pkg::RPL_LEN; // RL14
            nxt_hdr1[31:24] = rpl_chk; // RL14
            // A clear is saved too, so the empty histogram persists
            nxt_save  = act_ff[thc_pkg::ACT_SAVE_B] | act_ff[thc_pkg::ACT_CLR_B]; // RL6 RL8
            nxt_state = thc_pkg::S_FIN;
         end
         thc_pkg::S_FIN: begin
            // Reply was written one edge earlier, so the host never sees it half done
            nxt_done  = 1'b1; // RL10 RL22
            if (rc_ff == thc_pkg::RC_EXEC) begin
               nxt_rc = thc_pkg::RC_OK; // RL12
            end
            nxt_state = thc_pkg::S_IDLE;
         end
         default: begin
            nxt_state = thc_pkg::S_IDLE;
         end
      endcase
   end

   assign clr_hist = (state_ff == thc_pkg::S_EXEC) && act_ff[thc_pkg::ACT_CLR_B]; // RL8

   // ****************************************
   // Histogram counters
   // ****************************************
   // One sample per second; the sampling period is free to choose
   assign bin_idx = bin_of(temp_degc);

   always_comb begin
      nxt_tick = tick_ff + TICK_W'(1);
      for (int i = 0; i < thc_pkg::NWORDS; i++) begin
         nxt_cnt[i] = cnt_ff[i];
      end
      if (tick_ff == TICK_W'(SEC_CYC - 1)) begin // RL19
         nxt_tick   = '0;
         nxt_cnt[0] = cnt_ff[0] + 32'h0000_0001; // RL1
         nxt_cnt[bin_idx + 4'h1] = cnt_ff[bin_idx + 4'h1] + 32'h0000_0001; // RL1
      end
      // A clear beats a tick landing in the same cycle
      if (clr_hist) begin
         nxt_tick = '0;
         for (int i = 0; i < thc_pkg::NWORDS; i++) begin
            nxt_cnt[i] = 32'h0000_0000; // RL8
         end
      end
   end

   // ****************************************
   // State registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff  <= thc_pkg::S_IDLE;
         rc_ff     <= thc_pkg::RC_IDLE;
         done_ff   <= 1'b0;
         hdr0_ff   <= 32'h0000_0000;
         hdr1_ff   <= 32'h0000_0000;
         act_ff    <= 8'h00;
         save_ff   <= 1'b0;
         tick_ff   <= '0;
         prdata_ff <= 32'h0000_0000;
         for (int i = 0; i < thc_pkg::NWORDS; i++) begin
            reply_ff[i] <= 32'h0000_0000;
            cnt_ff[i]   <= 32'h0000_0000;
         end
      end else begin
         state_ff  <= nxt_state;
         rc_ff     <= nxt_rc;
         done_ff   <= nxt_done;
         hdr0_ff   <= nxt_hdr0;
         hdr1_ff   <= nxt_hdr1;
         act_ff    <= nxt_act;
         save_ff   <= nxt_save;
         tick_ff   <= nxt_tick;
         prdata_ff <= nxt_prdata;
         for (int i = 0; i < thc_pkg::NWORDS; i++) begin
            reply_ff[i] <= nxt_reply[i];
            cnt_ff[i]   <= nxt_cnt[i];
         end
      end
   end

   assign nv_save_req         = save_ff;
   assign command_done_flag   = done_ff;
   assign command_result_code = rc_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_start_capture: assert property ( // RL11
      (state_ff == thc_pkg::S_IDLE && wr_acc && paddr == thc_pkg::OFS_START && pwdata[0])
      |=> (rc_ff == thc_pkg::RC_CAPT && !done_ff) ##1 (rc_ff == thc_pkg::RC_CHECK))
      else $error("progress codes out of order");
   a_done_latency: assert property ( // RL10
      (state_ff == thc_pkg::S_IDLE && wr_acc && paddr == thc_pkg::OFS_START && pwdata[0])
      |-> ##[4:5] done_ff)
      else $error("done flag late");
   a_done_final: assert property ( // RL22
      $rose(done_ff) |-> !rc_ff[7] && $past(state_ff) == thc_pkg::S_FIN)
      else $error("done with busy code");
   a_chk_error: assert property ( // RL4
      (state_ff == thc_pkg::S_CHECK && {hdr0_ff[7:0], hdr0_ff[15:8]} == thc_pkg::CMD_ID
       && hdr1_ff[15:8] != cmd_chk) |=> rc_ff == thc_pkg::RC_CHK ##1 done_ff)
      else $error("check code mismatch missed");
   a_reply_len: assert property ( // RL14
      ($rose(done_ff) && rc_ff == thc_pkg::RC_OK) |-> hdr1_ff[23:16] == thc_pkg::RPL_LEN)
      else $error("reply length wrong");
   a_success_code: assert property ( // RL12
      (state_ff == thc_pkg::S_EXEC) |=> ##1 rc_ff == thc_pkg::RC_OK && done_ff)
      else $error("success code missing");
   a_clear_counts: assert property ( // RL8
      clr_hist |=> cnt_ff[0] == 32'h0000_0000 && nv_save_req)
      else $error("clear not applied");
   a_save_pulse: assert property ( // RL6
      (state_ff == thc_pkg::S_EXEC && act_ff[thc_pkg::ACT_SAVE_B]) |=> nv_save_req ##1 !nv_save_req)
      else $error("save pulse wrong");
   a_total_step: assert property ( // RL1
      ($changed(cnt_ff[0]) && !$past(clr_hist)) |-> cnt_ff[0] == $past(cnt_ff[0]) + 32'h1)
      else $error("total counter jumped");

   c_success: cover property ($rose(done_ff) && rc_ff == thc_pkg::RC_OK);
   c_chk_fail: cover property ($rose(done_ff) && rc_ff == thc_pkg::RC_CHK);
   c_clear: cover property (clr_hist);
   c_param_fail: cover property ($rose(done_ff) && rc_ff == thc_pkg::RC_PARAM);
endmodule

// *** bench/thc_host_model.sv ***
// Host controller model: APB master that builds and issues commands
`timescale 1ns/1ns
module thc_host_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic [31:0] rd_data;
   logic        rd_err;

   // ****************************************
   // Bus transfers
   // ****************************************
   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // One transfer; the request stands until pready is seen high
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench watchdog may end this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~data;  // Released data must not look still valid
   endtask

   // Header, action byte, launch; a bad check code only when asked
   task automatic send_cmd(input logic [15:0] id, input logic [7:0] lpl,
                           input logic [7:0] act, input logic bad);
      logic [7:0] chk;
      chk = ~(id[15:8] + id[7:0] + lpl + act);
      if (bad) begin
         chk = chk ^ 8'h01;
      end
      xfer(1'b1, thc_pkg::OFS_HDR0, {16'h0000, id[7:0], id[15:8]});
      xfer(1'b1, thc_pkg::OFS_HDR1, {8'h5a, 8'ha5, chk, lpl});
      xfer(1'b1, thc_pkg::OFS_ACT, {24'h000000, act});
      xfer(1'b1, thc_pkg::OFS_START, 32'h0000_0001);
   endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the temperature histogram command block
`timescale 1ns/1ns
module testbench;
   logic              pclk = 1'b0;
   logic              presetn = 1'b0;
   logic              psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata;
   logic signed [7:0] temp_degc = 8'sh19;
   logic              nv_save_req, command_done_flag;
   logic [7:0]        command_result_code;
   int                error_cnt = 0;
   int                tests_run = 0;
   int                save_cnt = 0;

   // ****************************************
   // Clock, reset, instances
   // ****************************************
   always #25 pclk = ~pclk;

   // Short second so a histogram fills in a few hundred cycles
   thc_cmd #(.SEC_CYC(10), .HOURS_SAVE(thc_pkg::HOURS_DEF)) thc_cmd_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .temp_degc(temp_degc),
      .nv_save_req(nv_save_req), .command_done_flag(command_done_flag),
      .command_result_code(command_result_code));

   thc_host_model thc_host_model_inst (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Save requests are pulses, so count them on every edge
   always @(posedge pclk) begin
      if (nv_save_req === 1'b1) begin
         save_cnt++;
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Launch a command and follow the result code edge by edge
   task automatic run_cmd(input logic [15:0] id, input logic [7:0] lpl, input logic [7:0] act,
                          input logic bad, input logic [7:0] code);
      logic [7:0] rc [1:5];
      logic       dn [1:5];
      int         s0;
      s0 = save_cnt;
      thc_host_model_inst.send_cmd(id, lpl, act, bad);
      // First sample falls just after the access edge that launched the command
      for (int i = 1; i <= 5; i++) begin
         #1;
         rc[i] = command_result_code;
         dn[i] = command_done_flag;
         @(posedge pclk);
      end
      check_val(rc[1], thc_pkg::RC_CAPT, "captured code");
      check_val(rc[2], thc_pkg::RC_CHECK, "checking code");
      if (code == thc_pkg::RC_OK) begin
         check_val(rc[4], thc_pkg::RC_EXEC, "executing code");
         check_val(dn[4], 1'b0, "early done");
         check_val(rc[5], code, "success code");
         check_val(dn[5], 1'b1, "done flag");
         check_val(save_cnt - s0, act[1] | act[7], "save pulses");
      end else begin
         check_val(rc[3], code, "failure code");
         check_val(dn[3], 1'b0, "early done");
         check_val(dn[4], 1'b1, "done flag");
         check_val(save_cnt - s0, 0, "save on failure");
      end
      thc_host_model_inst.xfer(1'b0, thc_pkg::OFS_STAT, 32'h0);
      check_val(thc_host_model_inst.rd_data, {22'h0, 2'b01, code}, "status");
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   // Idle status after reset, unmapped and unaligned places refused
   task automatic t_idle();
      thc_host_model_inst.xfer(1'b0, thc_pkg::OFS_STAT, 32'h0);
      check_val(thc_host_model_inst.rd_data, 32'h0, "reset status");
      check_val(thc_host_model_inst.rd_err, 1'b0, "mapped error");
      check_val(pready, 1'b1, "ready level");
      thc_host_model_inst.xfer(1'b0, 8'h14, 32'h0);
      check_val(thc_host_model_inst.rd_err, 1'b1, "unmapped error");
      thc_host_model_inst.xfer(1'b1, 8'h41, 32'h1);
      check_val(thc_host_model_inst.rd_err, 1'b1, "unaligned error");
   endtask

   // Refused commands: wrong id, bad check, bad length, reserved bits
   task automatic t_fail();
      run_cmd(16'h0291, 8'h01, 8'h04, 1'b0, thc_pkg::RC_FAIL);
      run_cmd(thc_pkg::CMD_ID, 8'h01, 8'h04, 1'b1, thc_pkg::RC_CHK);
      run_cmd(thc_pkg::CMD_ID, 8'h02, 8'h04, 1'b0, thc_pkg::RC_PARAM);
      run_cmd(thc_pkg::CMD_ID, 8'h01, 8'h05, 1'b0, thc_pkg::RC_PARAM);
      run_cmd(thc_pkg::CMD_ID, 8'h01, 8'h44, 1'b0, thc_pkg::RC_PARAM);
   endtask

   // Clear, dwell at one temperature, then save and return the histogram
   task automatic t_bin(input logic signed [7:0] t, input int k);
      logic [31:0] w [0:12];
      logic [7:0]  sum;
      temp_degc <= t;
      run_cmd(thc_pkg::CMD_ID, 8'h01, 8'h80, 1'b0, thc_pkg::RC_OK);
      repeat (60) @(posedge pclk);
      run_cmd(thc_pkg::CMD_ID, 8'h01, 8'h06, 1'b0, thc_pkg::RC_OK);
      sum = 8'h00;
      for (int i = 0; i < 13; i++) begin
         thc_host_model_inst.xfer(1'b0, thc_pkg::OFS_REPLY + 8'(4 * i), 32'h0);
         w[i] = thc_host_model_inst.rd_data;
         sum = sum + w[i][7:0] + w[i][15:8] + w[i][23:16] + w[i][31:24];
      end
      check_val(w[0], {16'h0, thc_pkg::HOURS_DEF, 8'h06}, "echo, hours");
      // About 80 cycles since the clear, ten cycles a second
      check_val(w[1] >= 7 && w[1] <= 9, 1'b1, "total seconds");
      for (int j = 0; j < 11; j++) begin
         check_val(w[2 + j] >= 7 && w[2 + j] <= 9, j == k, "bin count");
      end
      thc_host_model_inst.xfer(1'b0, thc_pkg::OFS_HDR1, 32'h0);
      check_val(thc_host_model_inst.rd_data[23:16], thc_pkg::RPL_LEN, "reply length");
      check_val(thc_host_model_inst.rd_data[31:24], 8'(~sum), "reply check");
   endtask

   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_idle();
      t_fail();
      t_bin(-8'sd6, 0);
      t_bin(-8'sd5, 1);
      t_bin(8'sd84, 9);
      t_bin(8'sd85, 10);
      give_verdict();
   end

   // All scenarios need well under 2000 cycles
   initial begin
      #(50 * 20000);
      error_cnt++;
      give_verdict();
   end
endmodule
